// *** core/shcp_port.v ***
`timescale 1ns/1ns
`default_nettype none
`include "shcp_map.vh"
// ==========================================================
// Serial host configuration port with register file.
// A frame is sixteen serial clock periods under an active chip select.
// The serial clock is sampled by the system clock, so it must stay well
// below a quarter of the system clock rate or edges will be missed.
// Pin mode turns the serial pins into plain level inputs.
// Read data leaves on the data out pin, which is released between reads.
module shcp_port #(
    parameter AW = `SHCP_ADDR_BITS,
    parameter DW = `SHCP_DATA_BITS
) (
    // Clock and reset.
    input  wire          i_clk,
    input  wire          i_resetn,
    // Mode select pin.
    input  wire          i_host_or_pin_mode_select,
    // Serial port pins.
    input  wire          i_cs_n,
    input  wire          i_sclk,
    input  wire          i_sdi,
    input  wire          i_sdo,
    output reg           o_sdo,
    output wire          o_sdo_oe_n,
    input  wire          i_irq_pin,
    output wire          o_irq_n,
    output wire          o_irq_oe_n,
    // Interrupt events from the line side.
    input  wire [DW-1:0] i_events,
    // Pin mode controls.
    output reg           o_receiver_monitor_select,
    output reg           o_receiver_power_select,
    output reg           o_loss_of_signal_mute,
    // Register contents for the rest of the chip.
    output reg  [DW-1:0] o_reg_wr_data,
    output reg  [AW-1:0] o_reg_wr_addr,
    output reg           o_reg_wr_stb,
    output reg           o_host_mode
);
    localparam FRAME = `SHCP_FRAME_BITS;

    // ==========================================================
    // Reset release.
    // Both flops clear at once; the internal reset rises two clocks after the
    // pin, so no flop leaves reset on an edge close to the pin change.
    reg rst1_q;
    reg rst_n;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst1_q <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst1_q <= 1'b1;
            rst_n  <= rst1_q;
        end
    end

    // ==========================================================
    // Pin synchronisers.
    // Every pin but the reset, the mode select included, crosses into the clock domain here.
    // Bit order: mode, chip select, clock, data in, data out pin, interrupt pin.
    wire [5:0] sync_q;
    shcp_sync #(
        .W(6)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_d     ({i_host_or_pin_mode_select, i_cs_n, i_sclk, i_sdi, i_sdo, i_irq_pin}),
        .o_q     (sync_q)
    );
    wire mode_s = sync_q[5];
    wire cs_s   = sync_q[4];
    wire sclk_s = sync_q[3];
    wire sdi_s  = sync_q[2];
    wire sdo_s  = sync_q[1];
    wire irqp_s = sync_q[0];

    // Serial clock edge detection on the synchronised copy.
    reg  sclk_q;
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
        end
    end
    // Host mode gates selection, so edges seen in pin mode do nothing.
    // Edge strobes last one system clock and are valid only while selected.
    wire host  = mode_s;                       // High selects host mode.
    wire sel   = host && !cs_s;
    wire rise  = sel && sclk_s && !sclk_q;
    wire fall  = sel && !sclk_s && sclk_q;

    // ==========================================================
    // Register file.
    // Every entry resets to one default; the status word is kept apart
    // because hardware events set its bits, not serial writes.
    reg [DW-1:0] regs [0:`SHCP_NUM_REGS-1];
    reg [DW-1:0] irq_st_q;

    // ==========================================================
    // Frame shifter.
    reg [`SHCP_CNT_W-1:0] cnt_q;
    reg [FRAME-2:0]       sh_q;
    reg                   rd_q;
    reg [DW-1:0]          tx_q;
    reg                   drv_q;
    wire [FRAME-1:0]      full_w = {sh_q, sdi_s};
    // The shifter holds the bits already taken; the live input completes the word.
    // The address is whole at the eighth rising edge, when the read data loads.
    wire [AW-1:0]         addr_w = full_w[AW-1:0];
    wire [DW-1:0]         rdat_w = (addr_w == `SHCP_IRQ_ST_OFF) ? irq_st_q : regs[addr_w];
    // A write completes on the sixteenth rising edge when the flag bit says write.
    wire                  wr_go  = rise && (cnt_q == FRAME - 1) && !sh_q[FRAME-2];
    // Loop index for the register reset.
    integer i;

    // Bit capture, read load and output drive.
    // Edges beyond the sixteenth are ignored, and a chip select that rises
    // early aborts the frame without a write.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Frame state and outputs start idle.
            cnt_q         <= {`SHCP_CNT_W{1'b0}};
            sh_q          <= {(FRAME-1){1'b0}};
            rd_q          <= 1'b0;
            tx_q          <= {DW{1'b0}};
            drv_q         <= 1'b0;
            o_sdo         <= 1'b0;
            o_reg_wr_stb  <= 1'b0;
            o_reg_wr_addr <= {AW{1'b0}};
            o_reg_wr_data <= {DW{1'b0}};
        end else begin
            o_reg_wr_stb <= 1'b0;
            if (!sel) begin
                cnt_q <= {`SHCP_CNT_W{1'b0}};
                drv_q <= 1'b0;                 // Output released after the frame.
            end else begin
                if (rise && cnt_q < FRAME) begin
                    sh_q  <= full_w[FRAME-2:0]; // Sample serial input.
                    cnt_q <= cnt_q + 1'b1;
                    // First bit is the read flag, then address.
                    if (cnt_q == 0) begin
                        rd_q <= (sdi_s == `SHCP_RW_READ);
                    end
                    if (cnt_q == AW && rd_q) begin
                        tx_q <= rdat_w;         // Load addressed contents.
                    end
                    if (cnt_q == FRAME - 1) begin
                        drv_q <= 1'b0;         // Read done; release.
                    end
                end
                // Hand a completed write to the register file for one cycle.
                if (wr_go) begin
                    o_reg_wr_stb  <= 1'b1;
                    o_reg_wr_addr <= sh_q[FRAME-3:DW-1];
                    o_reg_wr_data <= full_w[DW-1:0];
                end
                // Read data moves one bit per falling edge in the data phase.
                if (fall && rd_q && cnt_q > AW && cnt_q < FRAME) begin
                    drv_q <= 1'b1;
                    o_sdo <= tx_q[DW-1];       // Update on falling edge only.
                    tx_q  <= {tx_q[DW-2:0], 1'b0};
                end
            end
        end
    end
    // The data out pin is driven only during a read's data phase in host mode.
    assign o_sdo_oe_n = !(drv_q && host);

    // ==========================================================
    // Register storage; reset restores defaults.
    // Writes to the status offset go to the sticky status instead.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `SHCP_NUM_REGS; i = i + 1) begin
                regs[i] <= `SHCP_REG_RESET;    // Defaults on reset.
            end
        end else if (o_reg_wr_stb && o_reg_wr_addr != `SHCP_IRQ_ST_OFF) begin
            regs[o_reg_wr_addr] <= o_reg_wr_data;
        end
    end

    // Sticky events; a write of ones clears, a new event wins.
    // The event term is ORed in last, so an event beats a clear in one cycle.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_q <= {DW{1'b0}};
        end else if (o_reg_wr_stb && o_reg_wr_addr == `SHCP_IRQ_ST_OFF) begin
            irq_st_q <= (irq_st_q & ~o_reg_wr_data) | i_events; // Held until serviced.
        end else begin
            irq_st_q <= irq_st_q | i_events;
        end
    end
    // The request is the OR of enabled status bits, so it stays high until
    // software writes the status bit clear or disables it.
    // The pin is always driven in host mode; only its level carries the request.
    wire irq_w = |(irq_st_q & regs[`SHCP_IRQ_EN_OFF]);
    assign o_irq_n    = !irq_w;                // Active low, idles high.
    assign o_irq_oe_n = !host;

    // ==========================================================
    // Pin mode reuse of serial pins.
    // Copies hold their last value while the port is in host mode.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_receiver_monitor_select <= 1'b0;
            o_receiver_power_select   <= 1'b0;
            o_loss_of_signal_mute     <= 1'b0;
            o_host_mode               <= 1'b0;
        end else begin
            o_host_mode <= host;
            if (!host) begin
                o_receiver_monitor_select <= sdo_s;
                o_receiver_power_select   <= sdi_s;
                o_loss_of_signal_mute     <= irqp_s;
            end
        end
    end
endmodule
`default_nettype wire

// *** common/shcp_map.vh ***
// Function
// - On a read, shift the addressed register contents out on the serial data output.
// - Change serial data output only on falling serial clock edges.
// - Release serial data output to high impedance once a read finishes.
// - Capture each serial input bit on a rising serial clock edge.
// - In host mode, interrupt output idles high and goes low on enabled events.
// - Interrupt output stays low until the microprocessor services it.
// - Pulsing reset low returns every register to its default value.
// - In pin mode the data output pin is the receiver monitor select input.
// - In pin mode data input is power select; interrupt pin is mute input.
// - Mode select high means host mode, low means pin mode.
`ifndef SHCP_MAP_VH
`define SHCP_MAP_VH
// ==========================================================
// Frame layout.
`define SHCP_FRAME_BITS   16
`define SHCP_ADDR_BITS    7
`define SHCP_DATA_BITS    8
`define SHCP_CNT_W        5
`define SHCP_RW_READ      1'b1
// ==========================================================
// Register file.
`define SHCP_NUM_REGS     128
`define SHCP_REG_RESET    8'h00
// Interrupt enable register offset and event status register offset.
`define SHCP_IRQ_EN_OFF   7'h01
`define SHCP_IRQ_ST_OFF   7'h02
`endif

// *** core/shcp_sync.v ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Two-stage synchroniser, one per bit.
module shcp_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         i_clk,
    input  wire         i_rst_n,
    // Data.
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            // First stage feeds only the second stage.
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= i_d[g];
                    s2_q <= s1_q;
                end
            end
            assign o_q[g] = s2_q;
        end
    endgenerate
endmodule
`default_nettype wire

// *** bench/shcp_port_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Checker on the port pins.
module shcp_port_sva (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_host_or_pin_mode_select,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_sdo,
    input wire logic i_irq_pin,
    input wire logic o_sdo,
    input wire logic o_sdo_oe_n,
    input wire logic o_irq_n,
    input wire logic o_irq_oe_n,
    input wire logic o_receiver_monitor_select,
    input wire logic o_receiver_power_select,
    input wire logic o_loss_of_signal_mute,
    input wire logic o_reg_wr_stb,
    input wire logic o_host_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_sdo_edge: assert property ($changed(o_sdo) && !o_sdo_oe_n |-> !$past(i_sclk, 3) || !$past(i_sclk, 4))
        else $error("data out moved off a falling clock");
    chk_oe_release: assert property ($rose(i_cs_n) |-> ##[0:5] o_sdo_oe_n)
        else $error("data out not released");
    chk_oe_frame: assert property (!o_sdo_oe_n |-> !$past(i_cs_n, 6))
        else $error("data out driven outside a frame");
    chk_irq_drive: assert property (o_host_mode [*2] |-> !$past(o_irq_oe_n))
        else $error("interrupt pin not driven in host mode");
    chk_pin_quiet: assert property (!o_host_mode [*2] |-> $past(o_irq_oe_n) && $past(o_sdo_oe_n))
        else $error("pin driven in pin mode");
    chk_irq_hold: assert property ($rose(o_irq_n) |-> !o_host_mode || o_reg_wr_stb || $past(o_reg_wr_stb))
        else $error("interrupt dropped without service");
    chk_stb_pulse: assert property (o_reg_wr_stb |=> !o_reg_wr_stb [*8])
        else $error("write strobe too long");
    chk_stb_host: assert property (o_reg_wr_stb |-> o_host_mode)
        else $error("write taken in pin mode");
    chk_pin_copy: assert property ((!i_host_or_pin_mode_select && $stable({i_sdo, i_sdi, i_irq_pin})) [*5] |->
        {o_receiver_monitor_select, o_receiver_power_select, o_loss_of_signal_mute} == {i_sdo, i_sdi, i_irq_pin})
        else $error("pin mode copy wrong");
    cover property (o_reg_wr_stb);
    cover property ($fell(o_sdo_oe_n));
    cover property ($fell(o_irq_n));
endmodule
bind shcp_port shcp_port_sva i_shcp_port_sva (.i_clk, .i_resetn, .i_host_or_pin_mode_select, .i_cs_n, .i_sclk,
    .i_sdi, .i_sdo, .i_irq_pin, .o_sdo, .o_sdo_oe_n, .o_irq_n, .o_irq_oe_n, .o_receiver_monitor_select,
    .o_receiver_power_select, .o_loss_of_signal_mute, .o_reg_wr_stb, .o_host_mode);
`default_nettype wire

// *** bench/shcp_mst.sv ***
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Serial master; clock idles high, 320 ns period.
module shcp_mst (
    output logic        o_cs_n,
    output logic        o_sclk,
    output logic        o_sdi,
    input  wire logic   i_sdo,
    output logic        o_rd_done,
    output logic [15:0] o_frame
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_sdi = 1'b1;
        o_rd_done = 1'b0;
        o_frame = 16'h0000;
    end
    // Sends a frame of n periods; reads capture data out at each rise after the eighth.
    task automatic xfer(input logic [15:0] f, input int n);
        o_cs_n = 1'b0;
        #160;
        for (int k = 0; k < n; k++) begin
            o_sclk = 1'b0;
            o_sdi = f[15-k];
            #160;
            o_sclk = 1'b1;
            o_frame[15-k] = (k > 7 && f[15]) ? i_sdo : f[15-k];
            #160;
        end
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
        o_rd_done = f[15] && n == 16;
        #160;
        o_rd_done = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** bench/shcp_port_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Bench top.
module shcp_port_tb_top;
    logic        clk;
    logic        resetn;
    logic        mode;
    logic        cs_n;
    logic        sclk;
    logic        sdi_m;
    logic        rd_done;
    logic [2:0]  pin_v;
    logic [6:0]  a;
    logic [7:0]  d;
    logic [7:0]  st;
    logic [7:0]  events;
    logic [15:0] frame;
    logic [7:0]  mem [0:127];
    logic [15:0] expq [$];
    int          miscompares;
    int          total_checks;
    int          seed;
    wire         sdo, sdo_oe_n, irq_n, irq_oe_n, stb;
    wire  [6:0]  wadr;
    wire  [7:0]  wdat;
    wire  [2:0]  pins;
    // Released pins show noise or the pin-mode level.
    wire sdo_pin = !sdo_oe_n ? sdo : pin_v[2];
    wire irq_pin = !irq_oe_n ? irq_n : pin_v[0];
    wire sdi_pin = mode ? sdi_m : pin_v[1];
    shcp_port i_shcp_port (.i_clk(clk), .i_resetn(resetn), .i_host_or_pin_mode_select(mode), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi_pin), .i_sdo(sdo_pin), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_irq_pin(irq_pin),
        .o_irq_n(irq_n), .o_irq_oe_n(irq_oe_n), .i_events(events), .o_receiver_monitor_select(pins[2]),
        .o_receiver_power_select(pins[1]), .o_loss_of_signal_mute(pins[0]), .o_reg_wr_data(wdat),
        .o_reg_wr_addr(wadr), .o_reg_wr_stb(stb), .o_host_mode());
    shcp_mst i_shcp_mst (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi_m), .i_sdo(sdo_pin), .o_rd_done(rd_done),
        .o_frame(frame));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Monitor: each result takes the oldest note.
    always @(negedge clk) begin
        if (mode) pin_v <= 3'($random(seed));
        if (stb) cmp("write", expq.size() ? expq.pop_front() : 'x, {1'b0, wadr, wdat});
    end
    always @(posedge rd_done) cmp("read", expq.size() ? expq.pop_front() : 'x, frame);
    task automatic go(input logic rw, input logic [6:0] ad, input logic [7:0] dt, input int n);
        if (n == 16 && mode) expq.push_back({rw, ad, rw ? (ad == 7'h02 ? st : mem[ad]) : dt});
        if (n == 16 && mode && !rw) begin
            if (ad == 7'h02) st = st & ~dt;
            else mem[ad] = dt;
        end
        @(negedge clk);
        i_shcp_mst.xfer({rw, ad, dt}, n);
        repeat (6) @(negedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        close_out();
    end
    // Main sequence.
    initial begin
        {seed, miscompares, total_checks} = {32'd45528, 64'd0};
        {resetn, mode, events, pin_v, st} = {2'b01, 19'h0};
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        cmp("idle", 16'h0005, {irq_n, stb, sdo_oe_n});
        for (int k = 0; k < 6; k++) begin
            a = k ? 7'($random(seed)) : 7'h7f;
            d = 8'($random(seed));
            if (a inside {7'h01, 7'h02}) a = 7'h00;
            go(1'b0, a, d, 16);
            go(1'b1, a, ~d, 16);
        end
        go(1'b0, a, ~d, 10);
        go(1'b1, a, 8'h00, 16);
        go(1'b0, 7'h01, 8'h04, 16);
        for (int k = 0; k < 2; k++) begin
            events = k ? 8'h04 : 8'h01;
            @(negedge clk) events = 8'h00;
            st = st | (k ? 8'h04 : 8'h01);
            repeat (4) @(negedge clk);
            cmp("irq", {15'h0, !k}, {15'h0, irq_n});
        end
        go(1'b1, 7'h02, 8'h00, 16);
        cmp("irq", 16'h0000, {15'h0, irq_n});
        go(1'b0, 7'h02, 8'h04, 16);
        cmp("irq", 16'h0001, {15'h0, irq_n});
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        foreach (mem[i]) mem[i] = 8'h00;
        st = 8'h00;
        repeat (8) @(negedge clk);
        go(1'b1, 7'h01, 8'h00, 16);
        mode = 1'b0;
        for (int k = 0; k < 4; k++) begin
            pin_v = 3'($random(seed));
            repeat (10) @(negedge clk);
            cmp("pins", {13'h0, pin_v}, {13'h0, pins});
        end
        go(1'b0, 7'h10, 8'h5a, 16);
        mode = 1'b1;
        repeat (10) @(negedge clk);
        go(1'b1, 7'h10, 8'h00, 16);
        close_out();
    end
endmodule
`default_nettype wire
